// ---- hdl/ocs_pkg.sv ----
// Shared opcodes, reset values and field positions for the command decoder and its host end
package ocs_pkg;
  localparam logic [7:0] OP_AREA = 8'hD8;
  localparam logic [7:0] OP_PRECH = 8'hD9;
  localparam logic [7:0] OP_COMCFG = 8'hDA;
  localparam logic [7:0] OP_SCAN_UP = 8'hC0;
  localparam logic [7:0] OP_SCAN_DN = 8'hC8;
  localparam logic [7:0] OP_RMW_IN = 8'hE0;
  localparam logic [7:0] OP_RMW_OUT = 8'hEE;
  localparam logic [7:0] OP_HS_R = 8'h26;
  localparam logic [7:0] OP_HS_L = 8'h27;
  localparam logic [7:0] OP_VHS_R = 8'h29;
  localparam logic [7:0] OP_VHS_L = 8'h2A;
  localparam logic [7:0] OP_SC_OFF = 8'h2E;
  localparam logic [7:0] OP_SC_ON = 8'h2F;
  localparam logic [3:0] HS_PARAMS = 4'h4;
  localparam logic [3:0] VHS_PARAMS = 4'h5;
  localparam logic [7:0] PRECH_RST = 8'h02;
  localparam logic [7:0] COMCFG_RST = 8'h12;
  localparam int COMCFG_ALT_BIT = 4;
  localparam int COMCFG_SWAP_BIT = 5;
  localparam logic [7:0] NUM_COLS = 8'h84;
  localparam logic [5:0] NUM_ROWS_M1 = 6'h3F;
  localparam logic [7:0] ADDR_W = 8'h0B;
  localparam logic [11:0] PTR_LAST = 12'h41F;
  localparam int STAT_SCROLL_BIT = 6;
  localparam int STAT_RMW_BIT = 5;
  localparam int STAT_BUSY_BIT = 7;
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_CTRL = 8'h04;
  localparam logic [7:0] APB_STAT = 8'h08;
  localparam logic [7:0] APB_RDATA = 8'h0C;
endpackage : ocs_pkg

// ---- hdl/ocs_link_if.sv ----
// Host port between the controller and the decoder
`timescale 1ns/1ps
interface ocs_link_if;
  logic strobe;
  logic wr;
  logic dc;
  logic serial_sel;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  modport dev (input strobe, input wr, input dc, input serial_sel, input wdata,
               output rdata, output ack);
  modport host (output strobe, output wr, output dc, output serial_sel, output wdata,
                input rdata, input ack);
endinterface : ocs_link_if

// ---- hdl/ocs_device.sv ----
// Command decoder, memory pointer and scroll engine of the display driver
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module ocs_device
  import ocs_pkg::*;
#(
  parameter int FRAME_CYCLES = 1024
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Host link
  ocs_link_if.dev link,
  // Display configuration
  output logic area_color_q,
  output logic low_power_q,
  output logic [7:0] precharge_q,
  output logic com_alt_q,
  output logic com_swap_q,
  output logic scan_down_q,
  // Memory pointer and scroll state
  output logic [11:0] ptr_q,
  output logic rmw_q,
  output logic scroll_on_q,
  output logic scroll_left_q,
  output logic [7:0] col_shift_q,
  output logic [5:0] row_shift_q,
  output logic [2:0] start_page_q,
  output logic [2:0] end_page_q,
  output logic [2:0] interval_q,
  output logic [5:0] voffset_q,
  output logic [2:0] hstep_q
);
  typedef enum logic [2:0] {
    OC_IDLE = 3'b001,
    OC_ARG1 = 3'b010,
    OC_ARGN = 3'b100
  } ocs_dec_t;

  ocs_dec_t state_q;
  logic [7:0] op_q;
  logic [3:0] left_q;
  logic [3:0] idx_q;
  logic [11:0] saved_q;
  logic [7:0] mem_q [0:15];
  logic [15:0] frame_q;
  logic [2:0] frames_q;
  logic is_cmd;
  logic is_data_wr;
  logic is_data_rd;
  logic step;
  logic [7:0] status;
  logic [8:0] col_next;
  logic [6:0] row_next;

  assign is_cmd = link.strobe && link.wr && !link.dc;
  assign is_data_wr = link.strobe && link.wr && link.dc;
  assign is_data_rd = link.strobe && !link.wr && link.dc;
  assign status = {1'b0, scroll_on_q, rmw_q, 5'h00};

  // Command and parameter sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= OC_IDLE;
      op_q <= 8'h00;
      left_q <= 4'h0;
      idx_q <= 4'h0;
    end else if (is_cmd) begin
      unique case (state_q)
        OC_IDLE: begin
          op_q <= link.wdata;
          idx_q <= 4'h0;
          if (link.wdata == OP_HS_R || link.wdata == OP_HS_L) begin
            left_q <= HS_PARAMS;
            state_q <= OC_ARGN;
          end else if (link.wdata == OP_VHS_R || link.wdata == OP_VHS_L) begin
            left_q <= VHS_PARAMS;
            state_q <= OC_ARGN;
          end else if (link.wdata == OP_AREA || link.wdata == OP_PRECH
                       || link.wdata == OP_COMCFG) begin
            state_q <= OC_ARG1;
          end
        end
        OC_ARG1: state_q <= OC_IDLE;
        OC_ARGN: begin
          idx_q <= idx_q + 4'h1;
          left_q <= left_q - 4'h1;
          if (left_q == 4'h1) state_q <= OC_IDLE;
        end
        default: state_q <= OC_IDLE;
      endcase
    end
  end

  // Single-parameter configuration and scan direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      area_color_q <= 1'b0;
      low_power_q <= 1'b0;
      precharge_q <= PRECH_RST;
      com_alt_q <= COMCFG_RST[COMCFG_ALT_BIT];
      com_swap_q <= COMCFG_RST[COMCFG_SWAP_BIT];
      scan_down_q <= 1'b0;
    end else if (is_cmd) begin
      if (state_q == OC_ARG1 && op_q == OP_AREA) begin
        area_color_q <= link.wdata[0];
        low_power_q <= link.wdata[2];
      end
      if (state_q == OC_ARG1 && op_q == OP_PRECH) precharge_q <= link.wdata;
      if (state_q == OC_ARG1 && op_q == OP_COMCFG) begin
        com_alt_q <= link.wdata[COMCFG_ALT_BIT];
        com_swap_q <= link.wdata[COMCFG_SWAP_BIT];
      end
      if (state_q == OC_IDLE && link.wdata == OP_SCAN_UP) scan_down_q <= 1'b0;
      if (state_q == OC_IDLE && link.wdata == OP_SCAN_DN) scan_down_q <= 1'b1;
    end
  end

  // Scroll setup bytes; a new setup overwrites every field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scroll_left_q <= 1'b0;
      hstep_q <= 3'h0;
      start_page_q <= 3'h0;
      interval_q <= 3'h0;
      end_page_q <= 3'h0;
      voffset_q <= 6'h00;
    end else if (is_cmd && state_q == OC_IDLE && (link.wdata == OP_HS_R
                 || link.wdata == OP_HS_L || link.wdata == OP_VHS_R
                 || link.wdata == OP_VHS_L)) begin
      scroll_left_q <= (link.wdata == OP_HS_L || link.wdata == OP_VHS_L);
      hstep_q <= (link.wdata == OP_HS_R || link.wdata == OP_HS_L) ? 3'h1 : 3'h0;
      start_page_q <= 3'h0;
      interval_q <= 3'h0;
      end_page_q <= 3'h0;
      voffset_q <= 6'h00;
    end else if (is_cmd && state_q == OC_ARGN) begin
      if (op_q == OP_VHS_R || op_q == OP_VHS_L) begin
        unique case (idx_q)
          4'h0: hstep_q <= link.wdata[2:0];
          4'h1: start_page_q <= link.wdata[2:0];
          4'h2: interval_q <= link.wdata[2:0];
          4'h3: end_page_q <= link.wdata[2:0];
          4'h4: voffset_q <= link.wdata[5:0];
          default: ;
        endcase
      end else begin
        unique case (idx_q)
          4'h1: start_page_q <= link.wdata[2:0];
          4'h2: interval_q <= link.wdata[2:0];
          4'h3: end_page_q <= link.wdata[2:0];
          default: ;
        endcase
      end
    end
  end

  // Activate and deactivate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) scroll_on_q <= 1'b0;
    else if (is_cmd && state_q == OC_IDLE && link.wdata == OP_SC_ON) scroll_on_q <= 1'b1;
    else if (is_cmd && state_q == OC_IDLE && link.wdata == OP_SC_OFF) scroll_on_q <= 1'b0;
  end

  // Frame timing: one step every interval_q + 1 frames
  assign step = scroll_on_q && frame_q == 16'(FRAME_CYCLES - 1) && frames_q == interval_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_q <= 16'h0000;
      frames_q <= 3'h0;
    end else if (frame_q == 16'(FRAME_CYCLES - 1)) begin
      frame_q <= 16'h0000;
      frames_q <= (frames_q == interval_q || !scroll_on_q) ? 3'h0 : frames_q + 3'h1;
    end else begin
      frame_q <= frame_q + 16'h0001;
    end
  end

  // Cyclic shifts over all columns and all memory rows
  assign col_next = scroll_left_q ? {1'b0, col_shift_q} + {6'h00, hstep_q}
                  : {1'b0, col_shift_q} + {1'b0, NUM_COLS} - {6'h00, hstep_q};
  assign row_next = {1'b0, row_shift_q} + {1'b0, voffset_q};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_shift_q <= 8'h00;
      row_shift_q <= 6'h00;
    end else if (step) begin
      // Zero offset gives horizontal only, zero step gives vertical only
      col_shift_q <= (col_next >= {1'b0, NUM_COLS}) ? 8'(col_next - {1'b0, NUM_COLS})
                   : col_next[7:0];
      row_shift_q <= row_next[5:0] & NUM_ROWS_M1;
    end
  end

  // Memory pointer with read-modify-write save and restore
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rmw_q <= 1'b0;
      saved_q <= 12'h000;
      ptr_q <= 12'h000;
    end else if (is_cmd && state_q == OC_IDLE && link.wdata == OP_RMW_IN) begin
      rmw_q <= 1'b1;
      saved_q <= ptr_q;
    end else if (is_cmd && state_q == OC_IDLE && link.wdata == OP_RMW_OUT) begin
      rmw_q <= 1'b0;
      if (rmw_q) ptr_q <= saved_q;
    end else if (is_data_wr || (is_data_rd && !rmw_q)) begin
      ptr_q <= (ptr_q == PTR_LAST) ? 12'h000 : ptr_q + 12'h001;
    end
  end

  // Small display memory model indexed by the pointer's low bits
  always_ff @(posedge pclk) begin
    if (is_data_wr) mem_q[ptr_q[3:0]] <= link.wdata;
  end

  // Read answer: status on command select, none on serial
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.rdata <= 8'h00;
      link.ack <= 1'b0;
    end else begin
      link.ack <= link.strobe;
      if (link.strobe && !link.wr) begin
        if (link.serial_sel) link.rdata <= 8'h00;
        else if (!link.dc) link.rdata <= status;
        else link.rdata <= mem_q[ptr_q[3:0]];
      end
    end
  end
endmodule : ocs_device

// ---- hdl/ocs_host.sv ----
// APB-controlled host that issues bytes to the decoder
`timescale 1ns/1ps
module ocs_host
  import ocs_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host link
  ocs_link_if.host link
);
  logic busy_q;
  logic scroll_q;
  logic serial_q;
  logic blocked_q;
  logic [7:0] rbyte_q;
  logic acc;

  assign acc = psel && penable && pready;

  // APB answers one cycle after setup; link transfer runs in parallel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == APB_CMD || paddr == APB_CTRL
                 || paddr == APB_STAT || paddr == APB_RDATA);
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          APB_CTRL: prdata <= {31'h0, serial_q};
          APB_STAT: prdata <= {28'h0, blocked_q, scroll_q, serial_q, busy_q};
          APB_RDATA: prdata <= {24'h0, rbyte_q};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Command word: bit8 data select, bit9 read, bits 7:0 byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.strobe <= 1'b0;
      link.wr <= 1'b0;
      link.dc <= 1'b0;
      link.wdata <= 8'h00;
      busy_q <= 1'b0;
      scroll_q <= 1'b0;
      blocked_q <= 1'b0;
      rbyte_q <= 8'h00;
    end else begin
      link.strobe <= 1'b0;
      if (link.ack) begin
        busy_q <= 1'b0;
        if (!link.wr) rbyte_q <= link.rdata;
      end
      if (acc && pwrite && paddr == APB_CMD && !busy_q) begin
        if (pwdata[8] && scroll_q) begin
          blocked_q <= 1'b1;
        end else if (!pwdata[8] && pwdata[9] && serial_q) begin
          blocked_q <= 1'b1;
        end else if (!pwdata[9] && !pwdata[8] && scroll_q
                     && (pwdata[7:0] == OP_HS_R || pwdata[7:0] == OP_HS_L
                     || pwdata[7:0] == OP_VHS_R || pwdata[7:0] == OP_VHS_L)) begin
          blocked_q <= 1'b1;
        end else begin
          link.strobe <= 1'b1;
          link.wr <= !pwdata[9];
          link.dc <= pwdata[8];
          link.wdata <= pwdata[7:0];
          busy_q <= 1'b1;
          blocked_q <= 1'b0;
          if (!pwdata[9] && !pwdata[8] && pwdata[7:0] == OP_SC_ON) scroll_q <= 1'b1;
          if (!pwdata[9] && !pwdata[8] && pwdata[7:0] == OP_SC_OFF) scroll_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) serial_q <= 1'b0;
    else if (acc && pwrite && paddr == APB_CTRL) serial_q <= pwdata[0];
  end

  assign link.serial_sel = serial_q;
endmodule : ocs_host

// ---- test/ocs_scroll_sva.sv ----
// Concurrent checks on the host link and the decoder state
`timescale 1ns/1ps
module ocs_scroll_sva
  import ocs_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Host link
  input wire logic strobe,
  input wire logic wr,
  input wire logic dc,
  input wire logic serial_sel,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  // Decoder state
  input wire logic [7:0] precharge_q,
  input wire logic com_alt_q,
  input wire logic com_swap_q,
  input wire logic scan_down_q,
  input wire logic [11:0] ptr_q,
  input wire logic rmw_q,
  input wire logic scroll_on_q,
  input wire logic [7:0] col_shift_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] pend_q;
  logic [7:0] last_q;
  logic [11:0] saved_q;
  logic cmd;
  logic par;
  assign cmd = strobe && wr && !dc && pend_q == 4'h0;
  assign par = strobe && wr && !dc && pend_q != 4'h0;
  // Parameter bytes still owed to the command in progress
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 4'h0;
    end else if (cmd) begin
      pend_q <= (wdata == OP_HS_R || wdata == OP_HS_L) ? HS_PARAMS :
        (wdata == OP_VHS_R || wdata == OP_VHS_L) ? VHS_PARAMS :
        (wdata == OP_AREA || wdata == OP_PRECH || wdata == OP_COMCFG) ? 4'h1 : 4'h0;
    end else if (par) begin
      pend_q <= pend_q - 4'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q <= 8'h00;
      saved_q <= 12'h000;
    end else if (cmd) begin
      last_q <= wdata;
      saved_q <= (wdata == OP_RMW_IN) ? ptr_q : saved_q;
    end
  end
  a_scan_dir: assert property (cmd && (wdata == OP_SCAN_UP || wdata == OP_SCAN_DN)
    |=> scan_down_q == $past(wdata[3])) else $error("scan direction wrong");
  a_prech_take: assert property (par && last_q == OP_PRECH
    |=> precharge_q == $past(wdata)) else $error("precharge not taken");
  a_com_cfg: assert property (par && last_q == OP_COMCFG |=> com_alt_q == $past(wdata[4])
    && com_swap_q == $past(wdata[5])) else $error("row pin config wrong");
  a_rmw_enter: assert property (cmd && wdata == OP_RMW_IN
    |=> rmw_q && $stable(ptr_q)) else $error("mode entry wrong");
  a_rmw_read: assert property (rmw_q && strobe && !wr && dc
    |=> $stable(ptr_q)) else $error("pointer moved on read");
  a_rmw_write: assert property (rmw_q && !scroll_on_q && strobe && wr && dc && ptr_q != PTR_LAST
    |=> ptr_q == $past(ptr_q) + 12'h001) else $error("pointer not advanced");
  a_rmw_exit: assert property (cmd && wdata == OP_RMW_OUT && rmw_q
    |=> !rmw_q && ptr_q == $past(saved_q)) else $error("pointer not restored");
  a_stat_byte: assert property (strobe && !wr && !dc |=> rdata[STAT_RMW_BIT] == $past(rmw_q)
    && rdata[STAT_SCROLL_BIT] == $past(scroll_on_q)) else $error("status byte wrong");
  a_no_serial: assert property (serial_sel |-> !(strobe && !wr && !dc))
    else $error("status read on serial");
  a_no_ram: assert property (scroll_on_q |-> !(strobe && dc))
    else $error("memory access while scrolling");
  a_halt_hold: assert property (cmd && wdata == OP_SC_OFF
    |=> !scroll_on_q ##1 $stable(col_shift_q) [*4]) else $error("scroll not halted");
  a_col_wrap: assert property (col_shift_q < NUM_COLS)
    else $error("column shift out of span");
endmodule : ocs_scroll_sva

// ---- test/oled_cmd_scroll_rmw_test.sv ----
// Self-checking bench for the APB host and decoder joined by the link
`timescale 1ns/1ps
module oled_cmd_scroll_rmw_test;
  import ocs_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, area_color_q, low_power_q, com_alt_q, com_swap_q, scan_down_q;
  logic rmw_q, scroll_on_q, scroll_left_q;
  logic [7:0] precharge_q, col_shift_q;
  logic [11:0] ptr_q;
  logic [5:0] row_shift_q, voffset_q;
  logic [2:0] start_page_q, end_page_q, interval_q, hstep_q;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  logic [32:0] e_n, m_n;
  logic [7:0] ops [4] = '{OP_VHS_R, OP_HS_L, OP_VHS_L, OP_HS_R};
  int miscompares = 0;
  int checks_done = 0;
  integer seed = 32'h72F7;
  always #2 pclk = ~pclk;
  ocs_link_if link ();
  ocs_host ocs_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .link);
  ocs_device #(.FRAME_CYCLES(4)) ocs_device_i (.pclk, .presetn, .link, .area_color_q,
    .low_power_q, .precharge_q, .com_alt_q, .com_swap_q, .scan_down_q, .ptr_q, .rmw_q,
    .scroll_on_q, .scroll_left_q, .col_shift_q, .row_shift_q, .start_page_q, .end_page_q,
    .interval_q, .voffset_q, .hstep_q);
  ocs_scroll_sva ocs_scroll_sva_i (.pclk, .presetn, .strobe(link.strobe), .wr(link.wr),
    .dc(link.dc), .serial_sel(link.serial_sel), .wdata(link.wdata), .rdata(link.rdata),
    .precharge_q, .com_alt_q, .com_swap_q, .scan_down_q, .ptr_q, .rmw_q, .scroll_on_q,
    .col_shift_q);
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  // One APB transfer; pready is sampled at the rising edge, one idle cycle follows
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    logic [31:0] r;
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0, r);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  // Issue one link byte and poll the busy flag until it clears
  task automatic cmd(input logic [7:0] b, input logic dsel, input logic rdn);
    logic [31:0] r;
    int n;
    wr(APB_CMD, {22'h0, rdn, dsel, b});
    r = 32'h1;
    for (n = 0; n < 50 && r[0] !== 1'b0; n++) begin
      exp_q.push_back(33'h0);
      msk_q.push_back(33'h0);
      apb(1'b0, APB_STAT, 32'h0, r);
    end
  endtask : cmd
  always @(negedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      e_n = exp_q.pop_front();
      m_n = msk_q.pop_front();
      if (m_n != 33'h0) check("apb read", {pslverr, prdata} & m_n, e_n);
    end
  end
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
  initial begin
    logic [31:0] v;
    logic [11:0] p0;
    logic [7:0] c0;
    logic [5:0] r0;
    logic [7:0] pb [5];
    logic vh;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("precharge rst", precharge_q, PRECH_RST);
    check("area rst", area_color_q, 1'b0);
    check("row cfg rst", {com_swap_q, com_alt_q, scan_down_q}, 3'b010);
    rd(8'h10, 33'h1_0000_0000, 33'h1_0000_0000);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      cmd(OP_COMCFG, 1'b0, 1'b0);
      cmd((v[7:0] & 8'hCF) | {2'b00, i[1:0], 4'h0}, 1'b0, 1'b0);
      check("row cfg", {com_swap_q, com_alt_q}, i[1:0]);
      cmd(OP_PRECH, 1'b0, 1'b0);
      cmd(v[15:8] | 8'h01, 1'b0, 1'b0);
      check("precharge", precharge_q, v[15:8] | 8'h01);
      cmd(i[0] ? OP_SCAN_UP : OP_SCAN_DN, 1'b0, 1'b0);
      check("scan dir", scan_down_q, !i[0]);
      cmd(OP_AREA, 1'b0, 1'b0);
      cmd(v[23:16], 1'b0, 1'b0);
      check("area", area_color_q, v[16]);
    end
    cmd(8'h5A, 1'b1, 1'b0);
    p0 = ptr_q;
    cmd(OP_RMW_IN, 1'b0, 1'b0);
    cmd(8'h00, 1'b0, 1'b1);
    rd(APB_RDATA, {1'b0, 32'h20}, {1'b0, 32'h60});
    cmd(8'h00, 1'b1, 1'b1);
    check("ptr after read", ptr_q, p0);
    cmd(v[7:0], 1'b1, 1'b0);
    cmd(v[15:8], 1'b1, 1'b0);
    check("ptr after writes", ptr_q, p0 + 12'h002);
    cmd(OP_RMW_OUT, 1'b0, 1'b0);
    check("ptr restored", {rmw_q, ptr_q}, {1'b0, p0});
    wr(APB_CTRL, 32'h1);
    cmd(8'h00, 1'b0, 1'b1);
    rd(APB_STAT, {1'b0, 32'hA}, {1'b0, 32'hB});
    wr(APB_CTRL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      vh = ops[i] == OP_VHS_R || ops[i] == OP_VHS_L;
      pb = '{(i == 0) ? 8'h00 : {5'h0, v[2:0] | 3'h1}, {5'h0, v[5:3]}, 8'h00, 8'h07,
             {7'h0, vh}};
      cmd(OP_SC_OFF, 1'b0, 1'b0);
      cmd(ops[i], 1'b0, 1'b0);
      for (int k = 0; k < (vh ? VHS_PARAMS : HS_PARAMS); k++)
        cmd(pb[k], 1'b0, 1'b0);
      check("start page", start_page_q, v[5:3]);
      check("end page", end_page_q, 3'h7);
      check("direction", scroll_left_q, ops[i] == OP_HS_L || ops[i] == OP_VHS_L);
      check("voffset", voffset_q, {5'h0, vh});
      check("hstep", hstep_q, vh ? pb[0][2:0] : 3'h1);
      cmd(OP_SC_ON, 1'b0, 1'b0);
      check("scroll on", scroll_on_q, 1'b1);
      c0 = col_shift_q;
      r0 = row_shift_q;
      repeat (40) @(posedge pclk);
      check("col moved", col_shift_q !== c0, pb[0] != 8'h00 || !vh);
      check("row moved", row_shift_q !== r0, vh);
      cmd(v[15:8], 1'b1, 1'b0);
      rd(APB_STAT, {1'b0, 32'hC}, {1'b0, 32'hC});
      cmd(OP_SC_OFF, 1'b0, 1'b0);
      check("scroll off", scroll_on_q, 1'b0);
      cmd(v[23:16], 1'b1, 1'b0);
    end
    summarize();
  end
endmodule : oled_cmd_scroll_rmw_test
